// ==== rtl/buck_phase_and_tracking_control.sv ====
// Phase gang decode and termination rail sequencing for the buck regulator array
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module buck_phase_and_tracking_control (
  input  wire logic                            sys_clk,
  input  wire logic                            nrst,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [31:0]                     reg_rdata,
  input  wire logic                            seq_parent_on,
  input  wire logic                            seq_tracking_on,
  output logic      [phase_track_pkg::PHASE_W-1:0] rail_phase,
  output phase_track_pkg::gang_mode_t          group_a_mode,
  output phase_track_pkg::gang_mode_t          group_b_mode,
  output phase_track_pkg::gang_mode_t          group_c_mode,
  output logic                                 parent_enable,
  output logic                                 parent_pulldown_en,
  output logic      [7:0]                      parent_setpoint,
  output logic                                 tracking_enable,
  output logic                                 tracking_ref_follow,
  output logic      [7:0]                      tracking_dac_code,
  output logic                                 tracking_pulldown_en,
  output logic                                 tracking_highz
);
  import phase_track_pkg::*;

  phase_cfg_if pif ();

  logic [CFG_W-1:0]   cfg_reg;
  logic [PHASE_W-1:0] phase_sel_reg;
  logic [EN_W-1:0]    en_reg;
  logic [EN_W-1:0]    en_next;
  logic [7:0]         parent_run_reg;
  logic [7:0]         trk_run_reg;
  logic [7:0]         trk_stby_reg;
  logic [7:0]         trk_start_reg;
  logic               par_prev_reg;
  logic               trk_prev_reg;
  logic               trk_seq_reg;
  logic               par_seq_reg;
  trk_state_t         state_reg;
  trk_state_t         state_next;
  logic [7:0]         target_reg;
  logic [7:0]         target_next;
  logic [7:0]         dac_reg;
  logic [7:0]         dac_next;
  logic [5:0]         step_cnt_reg;

  wire par_en;
  wire trk_en;
  wire par_rise;
  wire trk_rise;
  wire same_slot;
  wire term_mode;
  wire pd_sel;
  wire at_target;
  wire step_due;
  wire wr_config;
  wire wr_phase;
  wire wr_enable;
  wire [31:0] status_word;
  wire [31:0] rd_word;

  phase_mapper u_mapper (
    .pif (pif.mapper)
  );

  assign pif.cfg_a = cfg_reg[CFG_A_LSB +: 2];
  assign pif.cfg_b = cfg_reg[CFG_B_LSB +: 2];
  assign pif.cfg_c = cfg_reg[CFG_C_LSB +: 2];
  assign pif.sel   = phase_sel_reg;

  // Register decode
  assign wr_config = reg_wr && (reg_addr == ADDR_CONFIG);
  assign wr_phase  = reg_wr && (reg_addr == ADDR_PHASE_SEL);
  assign wr_enable = reg_wr && (reg_addr == ADDR_ENABLE);

  // Sequencer pulses set the enables; a set in the same cycle as a clear wins
  assign en_next = (wr_enable ? reg_wdata[EN_W-1:0] : en_reg)
                 | {1'b0, seq_tracking_on, seq_parent_on};

  assign par_en    = en_reg[EN_PARENT_BIT];
  assign trk_en    = en_reg[EN_TRACK_BIT];
  assign par_rise  = par_en && !par_prev_reg;
  assign trk_rise  = trk_en && !trk_prev_reg;
  assign same_slot = par_rise && par_seq_reg && trk_seq_reg;
  assign term_mode = cfg_reg[CFG_TERM_BIT];
  assign pd_sel    = cfg_reg[CFG_PD_BIT];
  assign at_target = (dac_reg == target_reg);
  assign step_due  = (step_cnt_reg == RAMP_STEP_LAST);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_reg        <= CONFIG_RST;
      phase_sel_reg  <= PHASE_SEL_RST;
      en_reg         <= ENABLE_RST;
      parent_run_reg <= SETPOINT_RST;
      trk_run_reg    <= SETPOINT_RST;
      trk_stby_reg   <= SETPOINT_RST;
      trk_start_reg  <= SETPOINT_RST;
    end
    else
    begin
      en_reg <= en_next;
      if (wr_config)
        cfg_reg <= reg_wdata[CFG_W-1:0];
      if (wr_phase)
        phase_sel_reg <= reg_wdata[PHASE_W-1:0];
      if (reg_wr && reg_addr == ADDR_PARENT_RUN)
        parent_run_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == ADDR_TRACK_RUN)
        trk_run_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == ADDR_TRACK_STBY)
        trk_stby_reg <= reg_wdata[7:0];
      if (reg_wr && reg_addr == ADDR_TRACK_START)
        trk_start_reg <= reg_wdata[7:0];
    end
  end

  // Tracking rail sequencing
  always_comb
  begin
    state_next  = state_reg;
    target_next = target_reg;
    unique case (state_reg)
      TRK_OFF:
        if (trk_rise)
        begin
          if (term_mode && same_slot)
            state_next = TRK_FOLLOW;
          else
          begin
            state_next  = TRK_RAMP;
            target_next = trk_seq_reg ? trk_start_reg
                        : (en_reg[EN_STBY_BIT] ? trk_stby_reg : trk_run_reg);
          end
        end
      TRK_RAMP:
        if (!trk_en)
          state_next = TRK_OFF;
        else if (at_target && term_mode && par_en)
          state_next = TRK_FOLLOW;
      TRK_FOLLOW:
        if (!trk_en)
          state_next = TRK_OFF;
        else if (!term_mode)
          state_next = TRK_RAMP;
        else if (!par_en)
          state_next = TRK_DISCH;
      TRK_DISCH:
        if (!trk_en)
          state_next = TRK_OFF;
        else if (par_en)
          state_next = TRK_FOLLOW;
    endcase
  end

  // The slow ramp starts from zero on every fresh enable; the reference is handed to the divider
  // in termination mode once the ramp has landed with the parent enabled, or at once when both rails start in the same slot
  assign dac_next = (state_reg == TRK_OFF) ? 8'h00
                  : (state_reg == TRK_RAMP && step_due && !at_target)
                    ? ((dac_reg < target_reg) ? dac_reg + 8'h01 : dac_reg - 8'h01)
                    : dac_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= TRK_OFF;
      target_reg   <= SETPOINT_RST;
      dac_reg      <= SETPOINT_RST;
      step_cnt_reg <= 6'h00;
      par_prev_reg <= 1'b0;
      trk_prev_reg <= 1'b0;
      par_seq_reg  <= 1'b0;
      trk_seq_reg  <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      target_reg   <= target_next;
      dac_reg      <= dac_next;
      step_cnt_reg <= (state_reg != TRK_RAMP || step_due) ? 6'h00 : step_cnt_reg + 6'h01;
      par_prev_reg <= par_en;
      trk_prev_reg <= trk_en;
      par_seq_reg  <= seq_parent_on;
      trk_seq_reg  <= seq_tracking_on;
    end
  end

  assign status_word = {16'h0000, dac_reg, 4'h0, trk_en, state_reg == TRK_DISCH,
                        state_reg == TRK_FOLLOW, state_reg == TRK_RAMP};
  assign rd_word = (reg_addr == ADDR_CONFIG)      ? {24'h00_0000, cfg_reg}
                 : (reg_addr == ADDR_PHASE_SEL)   ? {14'h0000, phase_sel_reg}
                 : (reg_addr == ADDR_ENABLE)      ? {29'h0000_0000, en_reg}
                 : (reg_addr == ADDR_PARENT_RUN)  ? {24'h00_0000, parent_run_reg}
                 : (reg_addr == ADDR_TRACK_RUN)   ? {24'h00_0000, trk_run_reg}
                 : (reg_addr == ADDR_TRACK_STBY)  ? {24'h00_0000, trk_stby_reg}
                 : (reg_addr == ADDR_TRACK_START) ? {24'h00_0000, trk_start_reg}
                 : (reg_addr == ADDR_STATUS)      ? status_word
                 : (reg_addr == ADDR_PHASE_OUT)   ? {14'h0000, rail_phase}
                 : 32'h0000_0000;

  // All pin-facing outputs are registered so no decode glitch reaches the power stage
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata            <= 32'h0000_0000;
      rail_phase           <= PHASE_SEL_RST;
      group_a_mode         <= MODE_SINGLE;
      group_b_mode         <= MODE_SINGLE;
      group_c_mode         <= MODE_SINGLE;
      parent_enable        <= 1'b0;
      parent_pulldown_en   <= 1'b0;
      parent_setpoint      <= SETPOINT_RST;
      tracking_enable      <= 1'b0;
      tracking_ref_follow  <= 1'b0;
      tracking_dac_code    <= SETPOINT_RST;
      tracking_pulldown_en <= 1'b0;
      tracking_highz       <= 1'b1;
    end
    else
    begin
      reg_rdata            <= reg_rd ? rd_word : 32'h0000_0000;
      rail_phase           <= pif.eff;
      group_a_mode         <= pif.mode_a;
      group_b_mode         <= pif.mode_b;
      group_c_mode         <= pif.mode_c;
      parent_enable        <= par_en;
      parent_pulldown_en   <= !par_en;
      parent_setpoint      <= parent_run_reg;
      tracking_enable      <= state_reg != TRK_OFF;
      tracking_ref_follow  <= state_reg == TRK_FOLLOW || state_reg == TRK_DISCH;
      tracking_dac_code    <= dac_reg;
      tracking_pulldown_en <= state_reg == TRK_DISCH || (state_reg == TRK_OFF && pd_sel);
      tracking_highz       <= state_reg == TRK_OFF && !pd_sel;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_group_a_quad: assert property ((cfg_reg[1:0] == CFG_QUAD) |=> group_a_mode == MODE_QUAD)
    else $error("group A quad code not decoded");
  chk_group_b_dual: assert property ((cfg_reg[1:0] != CFG_QUAD && cfg_reg[3:2] == CFG_DUAL)
                                     |=> group_b_mode == MODE_DUAL)
    else $error("group B dual code not decoded");
  chk_quad_overrides_b: assert property ((cfg_reg[1:0] == CFG_QUAD) |=> group_b_mode == MODE_QUAD)
    else $error("group B field not ignored in quad");
  chk_quad_phase_steps: assert property ((group_a_mode == MODE_QUAD) |->
      rail_phase[5:3] == phase_shift(rail_phase[2:0], SHIFT_90) &&
      rail_phase[8:6] == phase_shift(rail_phase[2:0], SHIFT_180) &&
      rail_phase[11:9] == phase_shift(rail_phase[2:0], SHIFT_270))
    else $error("quad phase steps wrong");
  chk_dual_a_offset: assert property ((group_a_mode == MODE_DUAL) |->
      rail_phase[5:3] == phase_shift(rail_phase[2:0], SHIFT_180))
    else $error("rail two not opposite rail one");
  chk_dual_b_offset: assert property ((group_b_mode == MODE_DUAL) |->
      rail_phase[8:6] == phase_shift(rail_phase[11:9], SHIFT_180))
    else $error("rail three not opposite rail four");
  chk_group_c_decode: assert property ((cfg_reg[5:4] == CFG_DUAL) |=> group_c_mode == MODE_DUAL)
    else $error("group C dual code not decoded");
  chk_dual_c_offset: assert property ((group_c_mode == MODE_DUAL) |->
      rail_phase[17:15] == phase_shift(rail_phase[14:12], SHIFT_180))
    else $error("rail six not opposite rail five");
  chk_reserved_single: assert property ((cfg_reg[5] == 1'b1) |=> group_c_mode == MODE_SINGLE)
    else $error("reserved code not single phase");
  chk_same_slot_follow: assert property ((state_reg == TRK_OFF && trk_rise && same_slot && term_mode)
                                         |-> ##2 tracking_ref_follow && tracking_enable)
    else $error("same slot enable did not follow at once");
  chk_ramp_then_follow: assert property ((state_reg == TRK_RAMP && at_target && term_mode && par_en && trk_en)
                                         |-> ##2 tracking_ref_follow)
    else $error("tracking did not follow after ramp");
  chk_parent_off_discharge: assert property ((state_reg == TRK_FOLLOW && term_mode && trk_en && !par_en)
                                             |=> parent_pulldown_en ##1 (tracking_pulldown_en && tracking_ref_follow))
    else $error("rails not discharged together");
  chk_parent_back_follow: assert property ((state_reg == TRK_DISCH && trk_en && par_en)
                                           |-> ##2 tracking_ref_follow && !tracking_pulldown_en)
    else $error("tracking lost parent on re-enable");
  chk_off_pulldown_sel: assert property ((state_reg == TRK_OFF) |=>
      tracking_pulldown_en == $past(pd_sel) && tracking_highz == !$past(pd_sel))
    else $error("disabled tracking output state wrong");
  chk_ramp_no_follow: assert property ((state_reg == TRK_RAMP) |=> !tracking_ref_follow)
    else $error("reference handed over before ramp end");

  cov_quad: cover property (group_a_mode == MODE_QUAD);
  cov_same_slot: cover property (state_reg == TRK_OFF ##1 state_reg == TRK_FOLLOW);
  cov_ramp_follow: cover property (state_reg == TRK_RAMP ##1 state_reg == TRK_FOLLOW);
  cov_discharge_back: cover property (state_reg == TRK_DISCH ##1 state_reg == TRK_FOLLOW);

endmodule : buck_phase_and_tracking_control
`default_nettype wire

// ==== rtl/phase_track_pkg.sv ====
// Shared constants, types and phase arithmetic for the buck phase and tracking control
package phase_track_pkg;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_QUAD} gang_mode_t;
  typedef enum logic [1:0] {TRK_OFF, TRK_RAMP, TRK_FOLLOW, TRK_DISCH} trk_state_t;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_PHASE_SEL   = 8'h04;
  localparam logic [7:0] ADDR_ENABLE      = 8'h08;
  localparam logic [7:0] ADDR_PARENT_RUN  = 8'h0C;
  localparam logic [7:0] ADDR_TRACK_RUN   = 8'h10;
  localparam logic [7:0] ADDR_TRACK_STBY  = 8'h14;
  localparam logic [7:0] ADDR_TRACK_START = 8'h18;
  localparam logic [7:0] ADDR_STATUS      = 8'h1C;
  localparam logic [7:0] ADDR_PHASE_OUT   = 8'h20;

  // Configuration register fields
  localparam int CFG_A_LSB    = 0;
  localparam int CFG_B_LSB    = 2;
  localparam int CFG_C_LSB    = 4;
  localparam int CFG_PD_BIT   = 6;
  localparam int CFG_TERM_BIT = 7;
  localparam int CFG_W        = 8;

  // Enable register fields
  localparam int EN_PARENT_BIT = 0;
  localparam int EN_TRACK_BIT  = 1;
  localparam int EN_STBY_BIT   = 2;
  localparam int EN_W          = 3;

  // Phase select field: rail n occupies bits [3n-1:3n-3]
  localparam int PH_W    = 3;
  localparam int PHASE_W = 18;

  // Gang configuration codes
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_DUAL   = 2'h1;
  localparam logic [1:0] CFG_QUAD   = 2'h2;

  // Phase codes and offsets in 45 degree steps
  localparam logic [2:0] PHASE_ZERO = 3'h7;
  localparam logic [2:0] SHIFT_90   = 3'h2;
  localparam logic [2:0] SHIFT_180  = 3'h4;
  localparam logic [2:0] SHIFT_270  = 3'h6;

  // Reset values
  localparam logic [CFG_W-1:0]   CONFIG_RST    = 8'h00;
  localparam logic [PHASE_W-1:0] PHASE_SEL_RST = 18'h3_FFFF;
  localparam logic [EN_W-1:0]    ENABLE_RST    = 3'h0;
  localparam logic [7:0]         SETPOINT_RST  = 8'h00;

  // One setpoint code is 6.25 mV; the slow ramp moves 6.25 mV per microsecond
  localparam int CLK_PERIOD_NS    = 25;
  localparam int RAMP_STEP_NS     = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] RAMP_STEP_LAST = 6'(RAMP_STEP_CYCLES - 1);

  // Rotate a phase code by a number of 45 degree steps; code 7 stands for 0 degrees
  function automatic logic [2:0] phase_shift(input logic [2:0] code, input logic [2:0] steps);
    logic [2:0] idx;
    idx = (code == PHASE_ZERO) ? 3'h0 : code + 3'h1;
    idx = idx + steps;
    return (idx == 3'h0) ? PHASE_ZERO : idx - 3'h1;
  endfunction : phase_shift

endpackage : phase_track_pkg

// ==== rtl/phase_cfg_if.sv ====
// Interface between the control core and the phase mapper
`timescale 1ns/10ps
`default_nettype none
interface phase_cfg_if;
  import phase_track_pkg::*;
  logic [1:0]         cfg_a;
  logic [1:0]         cfg_b;
  logic [1:0]         cfg_c;
  logic [PHASE_W-1:0] sel;
  logic [PHASE_W-1:0] eff;
  gang_mode_t         mode_a;
  gang_mode_t         mode_b;
  gang_mode_t         mode_c;

  modport mapper (input cfg_a, cfg_b, cfg_c, sel, output eff, mode_a, mode_b, mode_c);
  modport ctrl   (output cfg_a, cfg_b, cfg_c, sel, input eff, mode_a, mode_b, mode_c);
endinterface : phase_cfg_if
`default_nettype wire

// ==== rtl/phase_mapper.sv ====
// Combinational decode of gang configuration into effective per-rail phases
`timescale 1ns/10ps
`default_nettype none
module phase_mapper (
  phase_cfg_if.mapper pif
);
  import phase_track_pkg::*;

  wire       quad_a;
  wire       dual_a;
  wire       dual_b;
  wire       dual_c;
  wire [2:0] s1;
  wire [2:0] s4;
  wire [2:0] s5;

  // Reserved codes fall through to single phase
  assign quad_a = (pif.cfg_a == CFG_QUAD);
  assign dual_a = (pif.cfg_a == CFG_DUAL);
  assign dual_b = !quad_a && (pif.cfg_b == CFG_DUAL);
  assign dual_c = (pif.cfg_c == CFG_DUAL);
  assign s1 = pif.sel[2:0];
  assign s4 = pif.sel[11:9];
  assign s5 = pif.sel[14:12];

  assign pif.mode_a = quad_a ? MODE_QUAD : (dual_a ? MODE_DUAL : MODE_SINGLE);
  assign pif.mode_b = quad_a ? MODE_QUAD : (dual_b ? MODE_DUAL : MODE_SINGLE);
  assign pif.mode_c = dual_c ? MODE_DUAL : MODE_SINGLE;

  // The governing rail keeps its own select; followers are rotated from it
  assign pif.eff[2:0]   = s1;
  assign pif.eff[5:3]   = quad_a ? phase_shift(s1, SHIFT_90)
                        : dual_a ? phase_shift(s1, SHIFT_180) : pif.sel[5:3];
  assign pif.eff[8:6]   = quad_a ? phase_shift(s1, SHIFT_180)
                        : dual_b ? phase_shift(s4, SHIFT_180) : pif.sel[8:6];
  assign pif.eff[11:9]  = quad_a ? phase_shift(s1, SHIFT_270) : s4;
  assign pif.eff[14:12] = s5;
  assign pif.eff[17:15] = dual_c ? phase_shift(s5, SHIFT_180) : pif.sel[17:15];

endmodule : phase_mapper
`default_nettype wire

// ==== verif/sys_ctrl_model.sv ====
// System controller model: register bus master and power-up sequencer pulses
`timescale 1ns/10ps
`default_nettype none
module sys_ctrl_model (
  input  wire logic        sys_clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata,
  output logic             seq_parent_on,
  output logic             seq_tracking_on
);
  import phase_track_pkg::*;
  // Parent kept at 1.2 V run and 1.0 V standby, above the termination floor
  localparam logic [7:0] PARENT_RUN_CODE  = 8'h80;
  localparam logic [7:0] PARENT_STBY_CODE = 8'h60;

  initial
  begin
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0000_0000;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    seq_parent_on   = 1'b0;
    seq_tracking_on = 1'b0;
  end

  // Codes step 6.25 mV from 400 mV, so half the voltage is p/2 - 32
  function automatic logic [7:0] half_code(input logic [7:0] p);
    return (p >> 1) - 8'h20;
  endfunction : half_code

  // Released lines carry the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic seq(input logic p, input logic t);
    @(posedge sys_clk);
    seq_parent_on   <= p;
    seq_tracking_on <= t;
    @(posedge sys_clk);
    seq_parent_on   <= 1'b0;
    seq_tracking_on <= 1'b0;
  endtask : seq

  task automatic setup_rails;
    wr(ADDR_PARENT_RUN, 32'(PARENT_RUN_CODE));
    wr(ADDR_TRACK_RUN, 32'(half_code(PARENT_RUN_CODE)));
    wr(ADDR_TRACK_STBY, 32'(half_code(PARENT_STBY_CODE)));
    wr(ADDR_TRACK_START, 32'h0000_0003);
  endtask : setup_rails
endmodule : sys_ctrl_model
`default_nettype wire

// ==== verif/buck_phase_and_tracking_control_tb.sv ====
// Self-checking testbench for the phase gang decode and termination rail sequencing
`timescale 1ns/10ps
`default_nettype none
module buck_phase_and_tracking_control_tb;
  import phase_track_pkg::*;
  logic               sys_clk = 1'b0;
  logic               nrst    = 1'b0;
  logic [7:0]         reg_addr, parent_setpoint, tracking_dac_code;
  logic [31:0]        reg_wdata, reg_rdata, rv;
  logic               reg_wr, reg_rd, seq_parent_on, seq_tracking_on;
  logic [PHASE_W-1:0] rail_phase;
  gang_mode_t         group_a_mode, group_b_mode, group_c_mode, ea, eb, ec;
  logic               parent_enable, parent_pulldown_en, tracking_enable;
  logic               tracking_ref_follow, tracking_pulldown_en, tracking_highz;
  logic [5:0]         c;
  int                 num_errors  = 0;
  int                 comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  sys_ctrl_model ctrl (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
                       .seq_parent_on, .seq_tracking_on);
  buck_phase_and_tracking_control dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .seq_parent_on, .seq_tracking_on, .rail_phase, .group_a_mode,
    .group_b_mode, .group_c_mode, .parent_enable, .parent_pulldown_en, .parent_setpoint,
    .tracking_enable, .tracking_ref_follow, .tracking_dac_code, .tracking_pulldown_en,
    .tracking_highz);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Bounded wait for the tracking reference to hand over to the parent
  task automatic wait_follow;
    int n;
    n = 0;
    while (tracking_ref_follow !== 1'b1 && n < 3000)
    begin
      settle(1);
      n++;
    end
    if (n == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_follow

  // Rotate a phase code by q steps of 45 degrees; code 7 is 0 degrees
  function automatic logic [2:0] rot(input logic [2:0] p, input int q);
    int d;
    d = (((p == 3'h7) ? 0 : int'(p) + 1) + q) % 8;
    return (d == 0) ? 3'h7 : 3'(d - 1);
  endfunction : rot

  function automatic logic [17:0] exp_ph(input logic [5:0] g, input logic [17:0] s);
    logic [2:0] r [1:6];
    for (int i = 1; i <= 6; i++)
      r[i] = s[3*i-3 +: 3];
    if (g[1:0] == 2'h2)
      for (int i = 2; i <= 4; i++)
        r[i] = rot(r[1], 2 * (i - 1));
    else
    begin
      if (g[1:0] == 2'h1)
        r[2] = rot(r[1], 4);
      if (g[3:2] == 2'h1)
        r[3] = rot(r[4], 4);
    end
    if (g[5:4] == 2'h1)
      r[6] = rot(r[5], 4);
    return {r[6], r[5], r[4], r[3], r[2], r[1]};
  endfunction : exp_ph

  initial
  begin
    settle(1);
    chk("reset phase", 32'h0003_FFFF, 32'(rail_phase));
    chk("reset highz", 32'h1, 32'(tracking_highz));
    repeat (7) @(posedge sys_clk);
    nrst <= 1'b1;
    ctrl.wr(ADDR_PHASE_SEL, 32'h0002_C688);
    for (int k = 0; k < 64; k++)
    begin
      c = 6'(k);
      ea = (c[1:0] == 2'h2) ? MODE_QUAD : (c[1:0] == 2'h1) ? MODE_DUAL : MODE_SINGLE;
      eb = (c[1:0] == 2'h2) ? MODE_QUAD : (c[3:2] == 2'h1) ? MODE_DUAL : MODE_SINGLE;
      ec = (c[5:4] == 2'h1) ? MODE_DUAL : MODE_SINGLE;
      ctrl.wr(ADDR_CONFIG, 32'(c));
      settle(3);
      chk("rail_phase", 32'(exp_ph(c, 18'h2_C688)), 32'(rail_phase));
      chk("modes", 32'({ea, eb, ec}), 32'({group_a_mode, group_b_mode, group_c_mode}));
    end
    ctrl.rd(ADDR_PHASE_OUT, rv);
    chk("phase read", 32'(exp_ph(6'h3F, 18'h2_C688)), rv);
    $display("phase decode test done");
    ctrl.setup_rails();
    ctrl.wr(ADDR_CONFIG, 32'h0000_0080);
    ctrl.seq(1'b1, 1'b1);
    settle(3);
    chk("same slot", 32'h7, 32'({tracking_enable, tracking_ref_follow, parent_enable}));
    chk("parent setpoint", 32'h80, 32'(parent_setpoint));
    ctrl.wr(ADDR_ENABLE, 32'h0000_0002);
    settle(3);
    chk("discharge", 32'h7, 32'({parent_pulldown_en, tracking_pulldown_en, tracking_ref_follow}));
    ctrl.wr(ADDR_ENABLE, 32'h0000_0003);
    settle(3);
    chk("parent back", 32'hA, 32'({parent_enable, parent_pulldown_en, tracking_ref_follow, tracking_pulldown_en}));
    $display("tracking follow test done");
    for (int pd = 0; pd < 2; pd++)
    begin
      ctrl.wr(ADDR_CONFIG, 32'h0000_0080 | 32'(pd << 6));
      ctrl.wr(ADDR_ENABLE, 32'h0000_0001);
      settle(3);
      chk("track off", 32'({1'b0, pd == 0, pd == 1}), 32'({tracking_enable, tracking_highz, tracking_pulldown_en}));
      ctrl.wr(ADDR_ENABLE, 32'h0000_0003 | 32'(pd << 2));
      settle(3);
      chk("ramping", 32'h2, 32'({tracking_enable, tracking_ref_follow}));
      wait_follow();
      chk("ramp end", (pd == 1) ? 32'h10 : 32'h20, 32'(tracking_dac_code));
    end
    $display("tracking disable test done");
    ctrl.wr(ADDR_ENABLE, 32'h0000_0000);
    settle(3);
    ctrl.seq(1'b1, 1'b0);
    settle(3);
    ctrl.seq(1'b0, 1'b1);
    settle(3);
    chk("later slot", 32'h2, 32'({tracking_enable, tracking_ref_follow}));
    wait_follow();
    chk("start code", 32'h3, 32'(tracking_dac_code));
    ctrl.rd(ADDR_STATUS, rv);
    chk("status", 32'h0000_030A, rv);
    $display("later slot test done");
    // Leaving termination mode hands the rail back to its own reference
    ctrl.wr(ADDR_CONFIG, 32'h0000_0000);
    settle(3);
    chk("term off", 32'h2, 32'({tracking_enable, tracking_ref_follow}));
    $display("termination off test done");
    report_and_stop();
  end
endmodule : buck_phase_and_tracking_control_tb
`default_nettype wire
